// ---- rtl/vram_pixel_pipeline.sv ----
// video memory timing, address mux, pixel shifter, palette and raster decode
// assumes cpu holds address/data steady for a whole 1 us slot once cpu_req is seen
// ===========================================================
`timescale 1ns/1ps
`include "vram_pixel_defines.svh"
module vram_pixel_pipeline
  import vram_pixel_pkg::*;
(
  input wire logic CORE_CLK_IN, // 20 MHz core clock
  input wire logic NRST_IN, // async reset, low active
  input wire logic CLOCKED_RESET_N_IN, // clocked reset pin, low active
  input wire logic CPU_REQ_IN, // cpu memory or page zero access request
  input wire logic CPU_RNW_IN, // 1 read, 0 write
  input wire logic [15:0] CPU_ADDR_IN, // cpu address
  input wire logic [7:0] CPU_DATA_IN, // cpu write data
  input wire logic PAGE0_SEL_N_IN, // page zero select, low active
  output logic [7:0] CPU_DATA_OUT, // read data to cpu
  output logic CPU_DATA_OE_OUT, // high while block drives data bus
  output logic CPU_DONE_OUT, // one-cycle end of cpu slot
  output logic [6:0] MEMORY_ADDR_LINES_OUT, // multiplexed memory address
  output logic RAS_N_OUT, // row strobe, low active
  output logic CAS_N_OUT, // column strobe, low active
  output logic [2:0] BANK_WE_N_OUT, // per-bank write enable, gated
  output logic [7:0] MEM_WDATA_OUT, // write data to banks
  input wire logic [23:0] MEM_RDATA_IN, // bank3, bank2, bank1 data
  output logic SHIFT_LOAD_N_OUT, // shifter load strobe, low active
  output logic ROW_COL_SELECT_OUT, // mux select 0
  output logic SCAN_OR_CPU_SELECT_OUT, // mux select 1
  output logic [2:0] RED_OUT, // red level
  output logic [2:0] GREEN_OUT, // green level
  output logic [1:0] BLUE_OUT, // blue level
  output logic HSYNC_OUT, // horizontal sync
  output logic VSYNC_OUT, // vertical sync
  output logic BLANK_OUT, // edge blanking
  output logic COUNT240_OUT, // bottom-of-screen interrupt source
  output logic PERIODIC_IRQ_OUT // 1 ms interrupt source
);
  // ===========================================================
  // input synchronisers
  logic [1:0] crst_sync_q;
  logic [23:0] rdata_s1_q, rdata_s2_q;
  logic crst_ok;
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      crst_sync_q <= 2'h0;
      rdata_s1_q <= 24'h0;
      rdata_s2_q <= 24'h0;
    end else begin
      crst_sync_q <= {crst_sync_q[0], CLOCKED_RESET_N_IN};
      rdata_s1_q <= MEM_RDATA_IN;
      rdata_s2_q <= rdata_s1_q;
    end
  end
  assign crst_ok = crst_sync_q[1];

  // ===========================================================
  // control decode: pseudo bits, bank selects, page zero
  function automatic logic [8:0] ctrl_decode(input logic [7:0] hi);
    // returns {bank_onehot[2:0], pseudo[5:0]}; banks are 64 pages of 256 bytes
    logic [2:0] bank;
    logic [5:0] ps;
    bank = 3'h0;
    ps = 6'h0;
    if (hi < 8'h40) begin
      bank = 3'h1;
      ps = hi[5:0];
    end else if (hi < 8'h80) begin
      bank = 3'h2;
      ps = hi[5:0];
    end else if (hi < 8'hc0) begin
      bank = 3'h4;
      ps = hi[5:0];
    end
    return {bank, ps};
  endfunction : ctrl_decode
  // page zero windows: c0xx palette, cbxx vertical count
  function automatic logic in_window(input logic [15:0] a, input logic [7:0] hi);
    return (a[15:8] == hi);
  endfunction : in_window

  logic [8:0] ctl;
  logic [2:0] bank_en;
  logic [5:0] pseudo_addr_bits;
  logic palette_write_sel_n, vcount_read_sel_n, cpu_is_mem;
  always_comb begin
    ctl = ctrl_decode(CPU_ADDR_IN[15:8]);
    bank_en = ctl[8:6];
    pseudo_addr_bits = ctl[5:0];
    palette_write_sel_n = !(!PAGE0_SEL_N_IN && in_window(CPU_ADDR_IN, 8'hc0)
                            && !CPU_RNW_IN);
    vcount_read_sel_n = !(!PAGE0_SEL_N_IN && in_window(CPU_ADDR_IN, 8'hcb)
                          && CPU_RNW_IN);
    cpu_is_mem = PAGE0_SEL_N_IN && (bank_en != 3'h0);
  end

  // ===========================================================
  // slot timing: 20 cycles per microsecond, scan half then cpu half
  logic [4:0] slot_q, slot_d;
  logic [2:0] tick_q, tick_d;
  scan_addr_t scan_q, scan_d;
  logic cpu_act_q, cpu_act_d;
  always_comb begin
    slot_d = (slot_q == 5'(`SLOT_CYCLES - 1)) ? 5'h0 : slot_q + 5'h1;
    tick_d = (tick_q == 3'(`SCAN_TICK_CYCLES - 1)) ? 3'h0 : tick_q + 3'h1;
    scan_d = scan_q;
    // counts 4 MHz ticks; bits 0-1 pick the quarter, bit 2 up the byte column
    if (tick_q == 3'h0) scan_d = scan_q + 14'h1;
    if (!crst_ok) scan_d = 14'h0;
    cpu_act_d = cpu_act_q;
    if (slot_q == 5'(`SLOT_RAS_CPU - 1)) cpu_act_d = CPU_REQ_IN;
    else if (slot_q == 5'(`SLOT_END_CPU)) cpu_act_d = 1'b0;
  end
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      slot_q <= 5'h0;
      tick_q <= 3'h0;
      scan_q <= 14'h0;
      cpu_act_q <= 1'b0;
    end else begin
      slot_q <= slot_d;
      tick_q <= tick_d;
      scan_q <= scan_d;
      cpu_act_q <= cpu_act_d;
    end
  end

  // ===========================================================
  // memory address and strobes
  addr_src_e src;
  logic [6:0] ma_d, ma_q;
  logic ras_d, ras_q, cas_d, cas_q, load_d, load_q, done_d, done_q;
  logic [2:0] we_d, we_q;
  logic cpu_mem;
  always_comb begin
    cpu_mem = cpu_act_q && cpu_is_mem;
    // scan owns slots 19 and 0..8, cpu owns 9..18; the registered lines follow one cycle later
    if (slot_q < 5'(`SLOT_RAS_CPU - 1) || slot_q == 5'(`SLOT_CYCLES - 1)) begin
      src = (slot_q >= 5'(`SLOT_CAS_SCAN - 1) && slot_q != 5'(`SLOT_CYCLES - 1))
            ? ADDR_SCAN_COL : ADDR_SCAN_ROW;
    end else begin
      src = (slot_q >= 5'(`SLOT_CAS_CPU - 1)) ? ADDR_CPU_COL : ADDR_CPU_ROW;
    end
    unique case (src)
      ADDR_CPU_ROW: ma_d = {pseudo_addr_bits, CPU_ADDR_IN[0]};
      ADDR_CPU_COL: ma_d = CPU_ADDR_IN[7:1];
      ADDR_SCAN_ROW: ma_d = scan_q[6:0];
      ADDR_SCAN_COL: ma_d = scan_q[13:7];
    endcase
    // strobes fall one cycle after the half they latch is on the lines, the scan row strobe two cycles after
    ras_d = !((slot_q >= 5'(`SLOT_RAS_SCAN) && slot_q < 5'(`SLOT_LOAD))
              || (cpu_mem && slot_q >= 5'(`SLOT_RAS_CPU)
                  && slot_q < 5'(`SLOT_END_CPU)));
    cas_d = !((slot_q >= 5'(`SLOT_CAS_SCAN) && slot_q < 5'(`SLOT_LOAD))
              || (cpu_mem && slot_q >= 5'(`SLOT_CAS_CPU)
                  && slot_q < 5'(`SLOT_END_CPU)));
    load_d = !(slot_q == 5'(`SLOT_LOAD) && tick_q == 3'h0 && crst_ok);
    we_d = 3'h7;
    if (cpu_mem && !CPU_RNW_IN && slot_q >= 5'(`SLOT_WE_CPU)
        && slot_q < 5'(`SLOT_END_CPU)) begin
      we_d = ~bank_en;
    end
    done_d = cpu_act_q && slot_q == 5'(`SLOT_END_CPU);
  end
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ma_q <= 7'h0;
      ras_q <= 1'b1;
      cas_q <= 1'b1;
      load_q <= 1'b1;
      we_q <= 3'h7;
      done_q <= 1'b0;
    end else begin
      ma_q <= ma_d;
      ras_q <= ras_d;
      cas_q <= cas_d;
      load_q <= load_d;
      we_q <= we_d;
      done_q <= done_d;
    end
  end
  assign MEMORY_ADDR_LINES_OUT = ma_q;
  assign RAS_N_OUT = ras_q;
  assign CAS_N_OUT = cas_q;
  assign BANK_WE_N_OUT = we_q;
  assign MEM_WDATA_OUT = CPU_DATA_IN;
  assign SHIFT_LOAD_N_OUT = load_q;
  assign ROW_COL_SELECT_OUT = src[0];
  assign SCAN_OR_CPU_SELECT_OUT = src[1];
  assign CPU_DONE_OUT = done_q;

  // ===========================================================
  // cpu read path and palette writes
  logic [7:0] rd_d, rd_q;
  logic oe_d, oe_q;
  logic [7:0] palette_q [16];
  logic [7:0] bank_byte;
  always_comb begin
    unique case (1'b1)
      bank_en[1]: bank_byte = rdata_s2_q[15:8];
      bank_en[2]: bank_byte = rdata_s2_q[23:16];
      default: bank_byte = rdata_s2_q[7:0];
    endcase
    rd_d = rd_q;
    oe_d = oe_q;
    if (done_d && CPU_RNW_IN) begin
      if (cpu_mem) begin
        rd_d = bank_byte;
        oe_d = 1'b1;
      end else if (!vcount_read_sel_n) begin
        rd_d = scan_q[13:6];
        oe_d = 1'b1;
      end
    end else if (!cpu_act_q) begin
      oe_d = 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rd_q <= 8'h0;
      oe_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      oe_q <= oe_d;
    end
  end
  assign CPU_DATA_OUT = rd_q;
  assign CPU_DATA_OE_OUT = oe_q;
  // palette is write-only from the cpu side
  always_ff @(posedge CORE_CLK_IN) begin
    if (done_d && !palette_write_sel_n) begin
      palette_q[CPU_ADDR_IN[`PAL_ADDR_W-1:0]] <= CPU_DATA_IN;
    end
  end

  // ===========================================================
  // shifter: six nibbles every microsecond
  logic [23:0] sh_q, sh_d;
  logic [2:0] left_q, left_d;
  logic [1:0] pdiv_q, pdiv_d;
  logic fifo_rdy, fifo_vld, push;
  pixel_t fifo_pix;
  always_comb begin
    pdiv_d = (pdiv_q == 2'(`PIX_PERIOD_CYCLES - 1)) ? 2'h0 : pdiv_q + 2'h1;
    push = (left_q != 3'h0) && pdiv_q == 2'h0 && fifo_rdy;
    sh_d = sh_q;
    left_d = left_q;
    if (push) begin
      sh_d = {sh_q[19:0], 4'h0};
      left_d = left_q - 3'h1;
    end
    if (!load_q && left_d == 3'h0) begin
      // bank1 high nibble goes first
      sh_d = {rdata_s2_q[7:0], rdata_s2_q[15:8], rdata_s2_q[23:16]};
      left_d = 3'h6;
    end
  end
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sh_q <= 24'h0;
      left_q <= 3'h0;
      pdiv_q <= 2'h0;
    end else begin
      sh_q <= sh_d;
      left_q <= left_d;
      pdiv_q <= pdiv_d;
    end
  end
  pixel_fifo #(.WIDTH(4), .DEPTH(`PIX_FIFO_DEPTH)) u_fifo (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(NRST_IN),
    .in_valid_in(push),
    .in_ready_out(fifo_rdy),
    .in_data_in(sh_q[23:20]),
    .out_valid_out(fifo_vld),
    .out_ready_in(pdiv_q == 2'h1),
    .out_data_out(fifo_pix)
  );

  // ===========================================================
  // palette lookup and raster decode
  logic [7:0] col_d, col_q;
  logic hs_d, hs_q, vs_d, vs_q, bl_d, bl_q, c240_d, c240_q, per_d, per_q;
  always_comb begin
    col_d = col_q;
    if (fifo_vld && pdiv_q == 2'h1) col_d = palette_q[fifo_pix];
    if (bl_q) col_d = 8'h0;
    hs_d = scan_q[7:2] >= `HSYNC_LO && scan_q[7:2] < `HSYNC_HI;
    vs_d = scan_q[13:6] >= `VSYNC_LO && scan_q[13:6] <= `VSYNC_HI;
    bl_d = scan_q[7:2] < `HBLANK_LO || scan_q[7:2] >= `HBLANK_HI;
    c240_d = scan_q[13:6] >= `VCOUNT_240;
    per_d = scan_q[`PERIODIC_BIT];
  end
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      col_q <= 8'h0;
      hs_q <= 1'b0;
      vs_q <= 1'b0;
      bl_q <= 1'b1;
      c240_q <= 1'b0;
      per_q <= 1'b0;
    end else begin
      col_q <= col_d;
      hs_q <= hs_d;
      vs_q <= vs_d;
      bl_q <= bl_d;
      c240_q <= c240_d;
      per_q <= per_d;
    end
  end
  assign RED_OUT = col_q[2:0];
  assign GREEN_OUT = col_q[5:3];
  assign BLUE_OUT = col_q[7:6];
  assign HSYNC_OUT = hs_q;
  assign VSYNC_OUT = vs_q;
  assign BLANK_OUT = bl_q;
  assign COUNT240_OUT = c240_q;
  assign PERIODIC_IRQ_OUT = per_q;
endmodule : vram_pixel_pipeline

// ---- include/vram_pixel_defines.svh ----
// constants for the video memory pixel pipeline
// assumes a single 20 MHz core clock drives every register
`ifndef VRAM_PIXEL_DEFINES_SVH
`define VRAM_PIXEL_DEFINES_SVH
`define CLK_PERIOD_NS 50
`define SCAN_PERIOD_NS 1000
`define SLOT_CYCLES (`SCAN_PERIOD_NS / `CLK_PERIOD_NS)
`define SCAN_TICK_NS 250
`define SCAN_TICK_CYCLES (`SCAN_TICK_NS / `CLK_PERIOD_NS)
`define PIX_PERIOD_CYCLES 3
`define SLOT_RAS_SCAN 1
`define SLOT_CAS_SCAN 3
`define SLOT_LOAD 5
`define SLOT_RAS_CPU 10
`define SLOT_CAS_CPU 12
`define SLOT_WE_CPU 14
`define SLOT_END_CPU 17
`define VCOUNT_240 8'hf0
`define VSYNC_LO 8'hf8
`define VSYNC_HI 8'hfb
`define HSYNC_LO 6'h36
`define HSYNC_HI 6'h38
`define HBLANK_LO 6'h02
`define HBLANK_HI 6'h34
`define PERIODIC_BIT 11
`define PAL_ADDR_W 4
`define PIX_FIFO_DEPTH 8
`endif

// ---- include/vram_pixel_pkg.sv ----
// types shared by the pixel pipeline files
// assumes the defines header supplies the numbers
package vram_pixel_pkg;
  typedef enum logic [1:0] {ADDR_CPU_ROW, ADDR_CPU_COL, ADDR_SCAN_ROW, ADDR_SCAN_COL} addr_src_e;
  typedef logic [13:0] scan_addr_t;
  typedef logic [3:0] pixel_t;
endpackage : vram_pixel_pkg

// ---- rtl/pixel_fifo.sv ----
// small valid/ready fifo between shifter and palette stage
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // async reset
  input wire logic in_valid_in, // write valid
  output logic in_ready_out, // not full
  input wire logic [WIDTH-1:0] in_data_in, // write data
  output logic out_valid_out, // not empty
  input wire logic out_ready_in, // read ready
  output logic [WIDTH-1:0] out_data_out // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;
  assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
  // storage carries no reset; valid flags guard it
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end
endmodule : pixel_fifo

// ---- dv/vram_bank_model.sv ----
// three dynamic memory banks facing the pixel pipeline
// assumes strobes and address lines are registered on the core clock
`timescale 1ns/1ps
module vram_bank_model (
  input wire logic clk_in, // core clock
  input wire logic ras_n_in, // row strobe
  input wire logic cas_n_in, // column strobe
  input wire logic [6:0] ma_in, // address lines
  input wire logic [2:0] we_n_in, // per-bank write enables
  input wire logic [7:0] wdata_in, // write data
  output logic [23:0] rdata_out // bank3, bank2, bank1
);
  logic [7:0] mem [3][16384];
  logic [6:0] row_q;
  logic [6:0] col_q;
  logic [6:0] col;
  logic ras_q = 1'b1;
  logic cas_q = 1'b1;
  logic [23:0] flip_q = 24'h000000;
  // =====================================================
  // storage
  initial begin
    for (int i = 0; i < 16384; i++) begin
      mem[0][i] = 8'h12;
      mem[1][i] = 8'h34;
      mem[2][i] = 8'h56;
    end
  end
  always @(posedge clk_in) begin
    if (ras_q && !ras_n_in) row_q <= ma_in;
    if (cas_q && !cas_n_in) col_q <= ma_in;
    ras_q <= ras_n_in;
    cas_q <= cas_n_in;
    for (int b = 0; b < 3; b++) begin
      if (!we_n_in[b] && !cas_n_in) mem[b][{col_q, row_q}] <= wdata_in;
    end
    // released output holds the last word for one cycle, then changes every cycle
    flip_q <= cas_n_in ? ~flip_q : rdata_out;
  end
  // =====================================================
  // read path
  assign col = cas_q ? ma_in : col_q;
  always_comb begin
    if (cas_n_in) rdata_out = flip_q;
    else rdata_out = {mem[2][{col, row_q}], mem[1][{col, row_q}],
                      mem[0][{col, row_q}]};
  end
endmodule : vram_bank_model

// ---- dv/vram_pixel_pipeline_checker.sv ----
// port-level checks of memory timing and cpu slots
// assumes bound to vram_pixel_pipeline, single core clock
`timescale 1ns/1ps
module vram_pixel_pipeline_checker (
  input wire logic CORE_CLK_IN, // clock
  input wire logic NRST_IN, // reset
  input wire logic CPU_REQ_IN, // cpu request
  input wire logic CPU_RNW_IN, // read not write
  input wire logic [7:0] CPU_DATA_IN, // cpu data
  input wire logic CPU_DATA_OE_OUT, // data drive
  input wire logic CPU_DONE_OUT, // slot end
  input wire logic RAS_N_OUT, // row strobe
  input wire logic CAS_N_OUT, // column strobe
  input wire logic [2:0] BANK_WE_N_OUT, // write enables
  input wire logic [7:0] MEM_WDATA_OUT, // memory data
  input wire logic SHIFT_LOAD_N_OUT, // load strobe
  input wire logic ROW_COL_SELECT_OUT, // mux select 0
  input wire logic SCAN_OR_CPU_SELECT_OUT // mux select 1
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // =====================================================
  // strobes and address halves
  row_first_a: assert property ($fell(RAS_N_OUT) |-> CAS_N_OUT)
    else $error("row strobe fell with column strobe low");
  col_after_a: assert property ($fell(CAS_N_OUT) |-> !RAS_N_OUT)
    else $error("column strobe without row strobe");
  row_sel_a: assert property ($fell(RAS_N_OUT) |-> !$past(ROW_COL_SELECT_OUT))
    else $error("row strobe with column half selected");
  col_sel_a: assert property ($fell(CAS_N_OUT) |-> $past(ROW_COL_SELECT_OUT))
    else $error("column strobe with row half selected");
  scan_sel_a: assert property (!SHIFT_LOAD_N_OUT |-> $past(SCAN_OR_CPU_SELECT_OUT, 3)
    && !$past(SCAN_OR_CPU_SELECT_OUT, 8))
    else $error("scan or cpu half selected in the wrong slot");
  // =====================================================
  // load strobe
  load_period_a: assert property ($fell(SHIFT_LOAD_N_OUT) |=> SHIFT_LOAD_N_OUT
    ##19 !SHIFT_LOAD_N_OUT)
    else $error("load strobe not one cycle every microsecond");
  load_idle_a: assert property (!SHIFT_LOAD_N_OUT |-> RAS_N_OUT && CAS_N_OUT)
    else $error("load strobe during memory access");
  // =====================================================
  // cpu slot
  we_gate_a: assert property (BANK_WE_N_OUT != 3'h7 |-> !RAS_N_OUT && !CAS_N_OUT
    && !CPU_RNW_IN && MEM_WDATA_OUT == CPU_DATA_IN)
    else $error("write enable outside gated cpu write");
  we_single_a: assert property ($onehot0(~BANK_WE_N_OUT))
    else $error("more than one bank written");
  done_slot_a: assert property (CPU_DONE_OUT |-> $past(CPU_REQ_IN, 9) ##1 !CPU_DONE_OUT)
    else $error("slot end without request nine cycles before");
  read_oe_a: assert property ($rose(CPU_DATA_OE_OUT) |-> CPU_DONE_OUT && CPU_RNW_IN)
    else $error("data bus driven outside a read");
  cover property ($fell(SHIFT_LOAD_N_OUT));
  cover property (BANK_WE_N_OUT != 3'h7);
  cover property ($rose(CPU_DATA_OE_OUT));
endmodule : vram_pixel_pipeline_checker
bind vram_pixel_pipeline vram_pixel_pipeline_checker i_chk (
  .CORE_CLK_IN(CORE_CLK_IN),
  .NRST_IN(NRST_IN),
  .CPU_REQ_IN(CPU_REQ_IN),
  .CPU_RNW_IN(CPU_RNW_IN),
  .CPU_DATA_IN(CPU_DATA_IN),
  .CPU_DATA_OE_OUT(CPU_DATA_OE_OUT),
  .CPU_DONE_OUT(CPU_DONE_OUT),
  .RAS_N_OUT(RAS_N_OUT),
  .CAS_N_OUT(CAS_N_OUT),
  .BANK_WE_N_OUT(BANK_WE_N_OUT),
  .MEM_WDATA_OUT(MEM_WDATA_OUT),
  .SHIFT_LOAD_N_OUT(SHIFT_LOAD_N_OUT),
  .ROW_COL_SELECT_OUT(ROW_COL_SELECT_OUT),
  .SCAN_OR_CPU_SELECT_OUT(SCAN_OR_CPU_SELECT_OUT)
);

// ---- dv/tb_vram_pixel_pipeline.sv ----
// self-checking bench for the pixel pipeline
// assumes the bank model of this folder and the bound checker
`timescale 1ns/1ps
`include "vram_pixel_defines.svh"
module tb_vram_pixel_pipeline;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cr_n = 1'b0;
  logic req = 1'b0;
  logic rnw = 1'b1;
  logic p0n = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wd = 8'h00;
  logic [7:0] rd;
  logic oe;
  logic [7:0] dout;
  logic [7:0] mwd;
  logic [6:0] ma;
  logic [2:0] we_n;
  logic [2:0] red;
  logic [2:0] grn;
  logic [1:0] blu;
  logic [23:0] mrd;
  logic doe, done, ras_n, cas_n, ld_n, hs, blk, c240, vs, per;
  int n_mismatch = 0;
  int checks = 0;
  always #25 clk = ~clk;
  vram_pixel_pipeline i_dut (.CORE_CLK_IN(clk), .NRST_IN(nrst), .CLOCKED_RESET_N_IN(cr_n),
    .CPU_REQ_IN(req), .CPU_RNW_IN(rnw), .CPU_ADDR_IN(addr), .CPU_DATA_IN(wd),
    .PAGE0_SEL_N_IN(p0n), .CPU_DATA_OUT(dout), .CPU_DATA_OE_OUT(doe), .CPU_DONE_OUT(done),
    .MEMORY_ADDR_LINES_OUT(ma), .RAS_N_OUT(ras_n), .CAS_N_OUT(cas_n), .BANK_WE_N_OUT(we_n),
    .MEM_WDATA_OUT(mwd), .MEM_RDATA_IN(mrd), .SHIFT_LOAD_N_OUT(ld_n),
    .ROW_COL_SELECT_OUT(), .SCAN_OR_CPU_SELECT_OUT(), .RED_OUT(red), .GREEN_OUT(grn),
    .BLUE_OUT(blu), .HSYNC_OUT(hs), .VSYNC_OUT(vs), .BLANK_OUT(blk), .COUNT240_OUT(c240),
    .PERIODIC_IRQ_OUT(per));
  vram_bank_model i_mem (.clk_in(clk), .ras_n_in(ras_n), .cas_n_in(cas_n), .ma_in(ma),
    .we_n_in(we_n), .wdata_in(mwd), .rdata_out(mrd));
  // =====================================================
  // shared tasks
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // request held from its edge until the slot end is seen
  task automatic cpu(input logic r, input logic [15:0] a, input logic [7:0] d, input logic pn);
    int i;
    @(posedge clk);
    req <= 1'b1;
    rnw <= r;
    addr <= a;
    wd <= d;
    p0n <= pn;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (done !== 1'b1 && i < 60);
    if (i >= 60) chk("cpu_done", 8'h01, 8'h00);
    rd = dout;
    oe = doe;
    @(posedge clk);
    req <= 1'b0;
  endtask : cpu
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // =====================================================
  // scenarios
  task automatic t_reset;
    cpu(1'b1, 16'hcb00, 8'h00, 1'b0);
    chk("vcount_held", 8'h00, rd);
    chk("vcount_oe", 8'h01, {7'h0, oe});
    @(posedge clk);
    cr_n <= 1'b1;
    // 4 MHz count: 2000 cycles plus slot wait gives 384..447 ticks
    repeat (2000) @(posedge clk);
    cpu(1'b1, 16'hcb00, 8'h00, 1'b0);
    chk("vcount_run", 8'h06, rd);
    chk("count240_low", 8'h00, {7'h0, c240});
    $display("test reset_count done");
  endtask : t_reset
  task automatic t_pixels;
    int k, good, prev, nh, nb;
    logic [7:0] c;
    for (k = 0; k < 16; k++) cpu(1'b0, 16'hc000 | 16'(k), {k[3:0], k[3:0]}, 1'b0);
    cpu(1'b1, 16'hc005, 8'h00, 1'b0);
    chk("palette_read_oe", 8'h00, {7'h0, oe});
    good = 0;
    prev = -1;
    nh = 0;
    nb = 0;
    repeat (2000) begin
      @(negedge clk);
      // rebuild the palette byte: red low, green middle, blue top
      c = {blu, grn, red};
      if (hs === 1'b1) nh++;
      if (blk === 1'b1) nb++;
      if (blk !== 1'b0 || c[7:4] !== c[3:0]) prev = -1;
      else if (int'(c[3:0]) != prev) begin
        if (prev >= 1 && prev <= 6) begin
          chk("pixel_order", 8'(prev % 6 + 1), {4'h0, c[3:0]});
          good++;
        end
        prev = int'(c[3:0]);
      end
    end
    chk("pixel_seen", 8'h01, {7'h0, good > 20});
    chk("hsync_toggles", 8'h01, {7'h0, nh > 0 && nh < 2000});
    chk("blank_toggles", 8'h01, {7'h0, nb > 0 && nb < 2000});
    $display("test pixels done");
  endtask : t_pixels
  task automatic t_vram;
    int b;
    logic [15:0] a;
    for (b = 0; b < 3; b++) begin
      a = {b[1:0], 14'h2b5b};
      cpu(1'b0, a, 8'ha0 | 8'(b), 1'b1);
    end
    for (b = 0; b < 3; b++) begin
      a = {b[1:0], 14'h2b5b};
      cpu(1'b1, a, 8'h00, 1'b1);
      chk("vram_read", 8'ha0 | 8'(b), rd);
      cpu(1'b1, a ^ 16'h0001, 8'h00, 1'b1);
      chk("vram_neighbour", 8'h12 + 8'(b) * 8'h22, rd);
    end
    cpu(1'b1, 16'he000, 8'h00, 1'b1);
    chk("unmapped_oe", 8'h00, {7'h0, oe});
    $display("test vram done");
  endtask : t_vram
  // long waits: the scan must climb most of a frame before the count240 and vsync decodes fire
  task automatic t_raster;
    int i;
    i = 0;
    while (per !== 1'b1 && i < 12000) begin
      @(negedge clk);
      i++;
    end
    cpu(1'b1, 16'hcb00, 8'h00, 1'b0);
    chk("periodic_rise", 8'h20, rd);
    i = 0;
    while (c240 !== 1'b1 && i < 80000) begin
      @(negedge clk);
      i++;
    end
    cpu(1'b1, 16'hcb00, 8'h00, 1'b0);
    chk("count240_rise", 8'hf0, rd);
    i = 0;
    while (vs !== 1'b1 && i < 4000) begin
      @(negedge clk);
      i++;
    end
    cpu(1'b1, 16'hcb00, 8'h00, 1'b0);
    chk("vsync_rise", `VSYNC_LO, rd);
    chk("count240_held", 8'h01, {7'h0, c240});
    $display("test raster done");
  endtask : t_raster
  // =====================================================
  // sequence and watchdog
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_pixels();
    t_vram();
    t_raster();
    summarize();
  end
  // a full frame is about 82k cycles; the raster test needs most of one
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule : tb_vram_pixel_pipeline
